/* common/phy_base_pkg.sv */
// constants for the serial-bus phy base register bank
// assumes a word-aligned avalon-mm slave with 32-bit data, one register per word
package phy_base_pkg;
    localparam logic [3:0] ADDR_PORTS = 4'h2;
    localparam logic [3:0] ADDR_SPEED = 4'h3;
    localparam logic [3:0] ADDR_LINK = 4'h4;
    localparam logic [3:0] ADDR_EVENT = 4'h5;
    localparam logic [3:0] ADDR_SELECT = 4'h7;
    localparam logic [3:0] ADDR_PORT0 = 4'h8;
    localparam logic [3:0] ADDR_PORT1 = 4'h9;
    localparam logic [3:0] TOTAL_PORTS = 4'h2;
    localparam logic [2:0] MAX_SPEED = 3'h2;
    localparam logic [3:0] REPEAT_DELAY = 4'h0;
    localparam logic [2:0] REPEAT_JITTER = 3'h0;
    localparam logic [2:0] EXTENDED_CODE = 3'h7;
    localparam logic [2:0] PAGE_PORT = 3'h0;
    // bit positions in register 5
    localparam int EV_WATCH = 7;
    localparam int EV_SHORT = 6;
    localparam int EV_LOOP = 5;
    localparam int EV_PFAIL = 4;
    localparam int EV_TMO = 3;
    localparam int EV_PORT = 2;
    localparam int EV_ACCEL = 1;
    localparam int EV_MULTI = 0;
    localparam int SELF_ID_LINK_BIT = 9;
    localparam int SELF_ID_C_BIT = 20;
    localparam int SELF_ID_PWR_LO = 21;
    localparam int SHORT_RESET_NS = 1300;
    localparam int CLOCK_NS = 8;
    localparam int SHORT_RESET_CYCLES = SHORT_RESET_NS / CLOCK_NS;
    localparam int STATUS_BITS = 4;
    typedef enum logic [2:0] {
        RST_IDLE = 3'h1,
        RST_WAIT = 3'h2,
        RST_DRIVE = 3'h4
    } reset_state_type;
endpackage

/* hdl/phy_base_registers.sv */
// base control and status register bank of a two-port serial-bus phy
// assumes the arbitration core supplies event pulses on this clock; pins are synchronised here
//
// Chosen here: the Avalon-MM register port and the register offsets.
module phy_base_registers
    import phy_base_pkg::*;
#(
    parameter int PORTS = 2
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic linkPowerStatusInput,
    input wire logic cablePowerStatusInput,
    input wire logic [2:0] powerClassConfigPins,
    input wire logic fundamentalReset,
    input wire logic globalResetInput,
    input wire logic powerOnReset,
    input wire logic busReset,
    input wire logic treeIdTimeout,
    input wire logic stateTimeout,
    input wire logic resumeStart,
    input wire logic [PORTS*STATUS_BITS-1:0] portStatus,
    input wire logic busIdle,
    input wire logic legacyOnBus,
    output logic selfIdLink,
    output logic [23:0] selfIdFields,
    output logic interfaceActive,
    output logic wakeLink,
    output logic busResetStart,
    output logic busResetShort,
    output logic busResetActive,
    output logic accelArbitration,
    output logic multiSpeedConcat,
    output logic [2:0] pageSelect,
    output logic [3:0] portSelect
);
    initial begin
        if (PORTS != 2) $error("only two ports supported");
    end

    logic linkActiveControl, contender;
    logic [2:0] powerClass;
    logic [7:0] eventReg;
    logic [PORTS-1:0] intEnable;
    logic [1:0] lpsSync, cpsSync, pcReset;
    logic [5:0] pinSync;
    logic cpsLast;
    logic [PORTS*STATUS_BITS-1:0] statusLast;
    reset_state_type state;
    logic [7:0] resetCount;
    logic ack;

    wire logic link_power_status_input = lpsSync[1];
    wire logic wr = write && ack;
    wire logic clr5 = wr && address == ADDR_EVENT;
    wire logic cpsFall = cpsLast && !cpsSync[1];
    logic portChange;
    always_comb begin
        portChange = 1'b0;
        for (int p = 0; p < PORTS; p++) begin
            if (intEnable[p] && portStatus[p*STATUS_BITS +: STATUS_BITS]
                != statusLast[p*STATUS_BITS +: STATUS_BITS])
                portChange = 1'b1;
        end
    end
    wire logic anyBusReset = busReset || busResetActive;

    // paged port registers answer only on the port page for an implemented port
    function automatic logic portPageHit(input logic [2:0] pg, input logic [3:0] ps);
        return (pg == PAGE_PORT) && (ps < PORTS);
    endfunction

    // straps keep shifting through reset so that the reset itself loads settled pins
    always_ff @(posedge clock) begin
        pinSync <= {pinSync[2:0], powerClassConfigPins};
    end

    // one wait state per access
    always_ff @(posedge clock) begin
        if (srst) ack <= 1'b0;
        else ack <= (read || write) && !ack;
    end
    assign waitrequest = (read || write) && !ack;

    always_ff @(posedge clock) begin
        if (srst) begin
            lpsSync <= 2'h0;
            cpsSync <= 2'h3;
            pcReset <= 2'h0;
            cpsLast <= 1'b1;
            statusLast <= '0;
        end else begin
            lpsSync <= {lpsSync[0], linkPowerStatusInput};
            cpsSync <= {cpsSync[0], cablePowerStatusInput};
            pcReset <= {pcReset[0], fundamentalReset || globalResetInput || powerOnReset};
            cpsLast <= cpsSync[1];
            statusLast <= portStatus;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            linkActiveControl <= 1'b1;
            contender <= 1'b0;
        end else if (wr && address == ADDR_LINK) begin
            linkActiveControl <= writedata[7];
            contender <= writedata[6];
        end
    end

    // power class loads from pins on srst and on fundamental, global or power-on reset, not on bus reset
    always_ff @(posedge clock) begin
        if (srst || pcReset[1]) powerClass <= pinSync[5:3];
        else if (wr && address == ADDR_LINK) powerClass <= writedata[2:0];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            eventReg <= 8'h00;
        end else begin
            if (wr && address == ADDR_EVENT) begin
                eventReg[EV_WATCH] <= writedata[EV_WATCH];
                eventReg[EV_ACCEL] <= writedata[EV_ACCEL];
                eventReg[EV_MULTI] <= writedata[EV_MULTI];
            end
            if (anyBusReset) eventReg[EV_SHORT] <= 1'b0;
            else if (wr && address == ADDR_EVENT && writedata[EV_SHORT])
                eventReg[EV_SHORT] <= 1'b1;
            // set beats write-one clear; zero writes keep the flag
            if (treeIdTimeout) eventReg[EV_LOOP] <= 1'b1;
            else if (clr5 && writedata[EV_LOOP]) eventReg[EV_LOOP] <= 1'b0;
            if (cpsFall) eventReg[EV_PFAIL] <= 1'b1;
            else if (clr5 && writedata[EV_PFAIL]) eventReg[EV_PFAIL] <= 1'b0;
            if (stateTimeout) eventReg[EV_TMO] <= 1'b1;
            else if (clr5 && writedata[EV_TMO]) eventReg[EV_TMO] <= 1'b0;
            if (portChange || (eventReg[EV_WATCH] && resumeStart))
                eventReg[EV_PORT] <= 1'b1;
            else if (clr5 && writedata[EV_PORT]) eventReg[EV_PORT] <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pageSelect <= 3'h0;
            portSelect <= 4'h0;
            intEnable <= '0;
        end else if (wr && address == ADDR_SELECT) begin
            portSelect <= writedata[7:4];
            pageSelect <= writedata[2:0];
        end else if (wr && address == ADDR_PORT1 && portPageHit(pageSelect, portSelect)) begin
            intEnable[portSelect[0]] <= writedata[4];
        end
    end

    // short reset sequencer; a legacy node only drops busResetShort, the length stays SHORT_RESET_CYCLES + 1 cycles
    always_ff @(posedge clock) begin
        if (srst) begin
            state <= RST_IDLE;
            resetCount <= 8'h00;
        end else begin
            case (state)
                RST_IDLE: if (stateTimeout) begin
                    state <= RST_DRIVE;
                    resetCount <= 8'(SHORT_RESET_CYCLES);
                end else if (eventReg[EV_SHORT]) state <= RST_WAIT;
                RST_WAIT: if (busIdle) begin
                    state <= RST_DRIVE;
                    resetCount <= 8'(SHORT_RESET_CYCLES);
                end
                RST_DRIVE: if (resetCount != 8'h00) resetCount <= resetCount - 8'h01;
                    else state <= RST_IDLE;
                default: state <= RST_IDLE;
            endcase
        end
    end
    assign busResetActive = state == RST_DRIVE;
    assign busResetStart = (state != RST_DRIVE) && (stateTimeout
        || (state == RST_WAIT && busIdle));
    assign busResetShort = busResetActive && !legacyOnBus;

    assign selfIdLink = linkActiveControl && link_power_status_input;
    assign interfaceActive = link_power_status_input;
    assign wakeLink = eventReg[EV_LOOP] && eventReg[EV_WATCH] && !selfIdLink;
    assign accelArbitration = eventReg[EV_ACCEL];
    assign multiSpeedConcat = eventReg[EV_MULTI];
    always_comb begin
        selfIdFields = 24'h000000;
        selfIdFields[SELF_ID_LINK_BIT] = selfIdLink;
        selfIdFields[SELF_ID_C_BIT] = contender;
        selfIdFields[SELF_ID_PWR_LO +: 3] = powerClass;
    end

    always_ff @(posedge clock) begin
        if (srst) readdata <= 32'h00000000;
        else if (read && !ack) begin
            readdata <= 32'h00000000;
            case (address)
                ADDR_PORTS: readdata[7:0] <= {EXTENDED_CODE, 1'b0, TOTAL_PORTS};
                ADDR_SPEED: readdata[7:0] <= {MAX_SPEED, 1'b0, REPEAT_DELAY};
                ADDR_LINK: readdata[7:0] <= {linkActiveControl, contender,
                    REPEAT_JITTER, powerClass};
                ADDR_EVENT: readdata[7:0] <= eventReg;
                ADDR_SELECT: readdata[7:0] <= {portSelect, 1'b0, pageSelect};
                ADDR_PORT0: if (portPageHit(pageSelect, portSelect))
                    readdata[3:0] <= portStatus[portSelect[0]*STATUS_BITS +: STATUS_BITS];
                ADDR_PORT1: if (portPageHit(pageSelect, portSelect))
                    readdata[4] <= intEnable[portSelect[0]];
                default: readdata <= 32'h00000000;
            endcase
        end
    end

    linkbit_a: assert property (@(posedge clock) disable iff (srst)
        selfIdFields[SELF_ID_LINK_BIT] == (linkActiveControl && lpsSync[1]))
        else $error("link bit");

    reset_link_active_control_a: assert property (@(posedge clock)
        $past(srst) |-> linkActiveControl)
        else $error("link control reset");

    link_active_control_keep_a: assert property (@(posedge clock) disable iff (srst)
        busReset && !(wr && address == ADDR_LINK)
        |=> linkActiveControl == $past(linkActiveControl))
        else $error("link control changed by bus reset");

    iface_lps_a: assert property (@(posedge clock) disable iff (srst)
        interfaceActive == lpsSync[1])
        else $error("interface state");

    contender_copy_a: assert property (@(posedge clock) disable iff (srst)
        selfIdFields[SELF_ID_C_BIT] == contender)
        else $error("contender bit");

    pwr_copy_a: assert property (@(posedge clock) disable iff (srst)
        selfIdFields[SELF_ID_PWR_LO +: 3] == powerClass)
        else $error("power class copy");

    pwr_reload_a: assert property (@(posedge clock) disable iff (srst)
        pcReset[1]
        |=> powerClass == $past(pinSync[5:3]))
        else $error("power class reload");

    ports_read_a: assert property (@(posedge clock) disable iff (srst)
        read && !ack && address == ADDR_PORTS
        |=> readdata[7:0] == {EXTENDED_CODE, 1'b0, TOTAL_PORTS})
        else $error("port count");

    speed_read_a: assert property (@(posedge clock) disable iff (srst)
        read && !ack && address == ADDR_SPEED
        |=> readdata[7:0] == {MAX_SPEED, 1'b0, REPEAT_DELAY})
        else $error("speed and delay");

    jitter_read_a: assert property (@(posedge clock) disable iff (srst)
        read && !ack && address == ADDR_LINK
        |=> readdata[5:3] == REPEAT_JITTER)
        else $error("jitter");

    loop_set_a: assert property (@(posedge clock) disable iff (srst)
        treeIdTimeout
        |=> eventReg[EV_LOOP])
        else $error("loop flag");

    loop_clear_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && writedata[EV_LOOP] && !treeIdTimeout
        |=> !eventReg[EV_LOOP])
        else $error("loop clear");

    pfail_set_a: assert property (@(posedge clock) disable iff (srst)
        cpsFall
        |=> eventReg[EV_PFAIL])
        else $error("power fail");

    pfail_clear_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && writedata[EV_PFAIL] && !cpsFall
        |=> !eventReg[EV_PFAIL])
        else $error("power fail clear");

    tmo_reset_a: assert property (@(posedge clock) disable iff (srst)
        stateTimeout && state != RST_DRIVE
        |=> busResetActive && eventReg[EV_TMO])
        else $error("timeout reset");

    zero_keep_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && !writedata[EV_LOOP] && eventReg[EV_LOOP]
        |=> eventReg[EV_LOOP])
        else $error("zero write cleared");

    tmo_keep_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && !writedata[EV_TMO] && eventReg[EV_TMO]
        |=> eventReg[EV_TMO])
        else $error("zero write cleared timeout");

    port_keep_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && !writedata[EV_PORT] && eventReg[EV_PORT]
        |=> eventReg[EV_PORT])
        else $error("zero write cleared port event");

    watch_resume_a: assert property (@(posedge clock) disable iff (srst)
        eventReg[EV_WATCH] && resumeStart
        |=> eventReg[EV_PORT])
        else $error("resume event");

    port_event_a: assert property (@(posedge clock) disable iff (srst)
        portChange
        |=> eventReg[EV_PORT])
        else $error("port event");

    int_enable_a: assert property (@(posedge clock) disable iff (srst)
        wr && address == ADDR_PORT1 && portPageHit(pageSelect, portSelect)
        |=> intEnable[$past(portSelect[0])] == $past(writedata[4]))
        else $error("interrupt enable");

    short_set_a: assert property (@(posedge clock) disable iff (srst)
        clr5 && writedata[EV_SHORT] && !anyBusReset
        |=> eventReg[EV_SHORT])
        else $error("short request set");

    short_clear_a: assert property (@(posedge clock) disable iff (srst)
        busResetActive
        |=> !eventReg[EV_SHORT])
        else $error("short request");

    short_start_a: assert property (@(posedge clock) disable iff (srst)
        state == RST_WAIT && busIdle
        |=> busResetActive)
        else $error("short reset start");

    start_active_a: assert property (@(posedge clock) disable iff (srst)
        busResetStart
        |=> busResetActive)
        else $error("reset start");

    count_bound_a: assert property (@(posedge clock) disable iff (srst)
        busResetActive
        |-> resetCount <= 8'(SHORT_RESET_CYCLES))
        else $error("reset length");

    short_kind_a: assert property (@(posedge clock) disable iff (srst)
        busResetActive
        |-> busResetShort == !legacyOnBus)
        else $error("reset kind");

    wake_link_a: assert property (@(posedge clock) disable iff (srst)
        eventReg[EV_LOOP] && eventReg[EV_WATCH] && !selfIdLink
        |-> wakeLink)
        else $error("wake");

    accel_keep_a: assert property (@(posedge clock) disable iff (srst)
        !(wr && address == ADDR_EVENT)
        |=> $stable(accelArbitration) && $stable(multiSpeedConcat))
        else $error("enable bits changed");

    accel_write_a: assert property (@(posedge clock) disable iff (srst)
        wr && address == ADDR_EVENT
        |=> accelArbitration == $past(writedata[EV_ACCEL]))
        else $error("accel write");

    select_keep_a: assert property (@(posedge clock) disable iff (srst)
        !(wr && address == ADDR_SELECT)
        |=> $stable(pageSelect) && $stable(portSelect))
        else $error("selectors changed");

    select_write_a: assert property (@(posedge clock) disable iff (srst)
        wr && address == ADDR_SELECT
        |=> pageSelect == $past(writedata[2:0]) && portSelect == $past(writedata[7:4]))
        else $error("selector write");

    page_reset_a: assert property (@(posedge clock)
        $past(srst) |-> pageSelect == 3'h0 && portSelect == 4'h0)
        else $error("select reset");
endmodule

/* test/link_model.sv */
// link-side partner: drives the link power status pin
// assumes the bench asks it to sleep; a wake request from the phy overrides that
module link_model (
    input wire logic clock,
    input wire logic srst,
    input wire logic sleepReq,
    input wire logic wakeLink,
    output logic link_power_status_input
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clock) begin
        if (srst) begin
            link_power_status_input <= 1'h1;
        end else if (wakeLink) begin
            link_power_status_input <= 1'h1;
        end else if (sleepReq) begin
            link_power_status_input <= 1'h0;
        end
    end
endmodule

/* test/testbench.sv */
// self-checking bench for the phy base register bank
// assumes the link model on the power status pin; stimulus is fixed, no random values
module testbench;
    import phy_base_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'h0, srst = 1'h1, read = 1'h0, write = 1'h0, sleepReq = 1'h0, cable_power_status_input = 1'h1;
    logic busIdle = 1'h0, legacy = 1'h0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [4:0] pul = 5'h00;
    logic [2:0] pins = 3'h5, pageSelect;
    logic [7:0] portStatus = 8'h00;
    logic [23:0] selfIdFields;
    logic [3:0] portSelect;
    logic waitrequest, link_power_status_input, selfIdLink, interfaceActive, wakeLink, rstStart, rstShort, accel, multi;
    logic rstActive;
    int errTotal = 0, nTests = 0;
    phy_base_registers u_dut (
        .clock, .srst, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .linkPowerStatusInput(link_power_status_input), .cablePowerStatusInput(cable_power_status_input), .powerClassConfigPins(pins),
        .fundamentalReset(1'h0), .globalResetInput(pul[4]), .powerOnReset(1'h0),
        .busReset(pul[3]), .treeIdTimeout(pul[0]), .stateTimeout(pul[1]), .resumeStart(pul[2]),
        .portStatus, .busIdle, .legacyOnBus(legacy), .selfIdLink, .selfIdFields,
        .interfaceActive, .wakeLink, .busResetStart(rstStart), .busResetShort(rstShort),
        .busResetActive(rstActive), .accelArbitration(accel), .multiSpeedConcat(multi), .pageSelect,
        .portSelect
    );
    link_model u_link (.clock, .srst, .sleepReq, .wakeLink, .link_power_status_input);
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            errTotal++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // held until waitrequest is seen low; read data is taken in that same cycle
    task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] d);
        int n;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'h0 && n < 20);
        if (waitrequest !== 1'h0) begin
            errTotal++;
            closeOut();
        end
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
        @(negedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        bus(a, 1'h0, 8'h00);
        chk($sformatf("register %0h", a), {24'h0, e}, q);
    endtask
    task automatic pulse(input int i);
        @(posedge clock);
        pul[i] <= 1'h1;
        @(posedge clock);
        pul[i] <= 1'h0;
    endtask
    task automatic waitv(ref logic s, input int lim, input string nm);
        int n;
        n = 0;
        while (s !== 1'h1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        nTests++;
        if (s !== 1'h1) begin
            $display("CHECK FAILED %s expected 1 seen %b", nm, s);
            errTotal++;
            closeOut();
        end
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        while (rstActive !== 1'h0 && n < 400) begin
            @(negedge clock);
            n++;
        end
        chk("reset active", 32'h0, {31'h0, rstActive});
        if (rstActive !== 1'h0) closeOut();
    endtask
    task automatic tReset();
        rd(4'h2, 8'hE2);
        rd(4'h3, 8'h40);
        rd(4'h4, 8'h85);
        rd(4'h5, 8'h00);
        rd(4'h7, 8'h00);
        rd(4'h6, 8'h00);
    endtask
    task automatic tLink();
        wr(4'h4, 8'h45);
        chk("contender", 32'h1, {31'h0, selfIdFields[SELF_ID_C_BIT]});
        chk("power class", 32'h5, {29'h0, selfIdFields[23:21]});
        chk("self id link", 32'h0, {31'h0, selfIdLink});
        chk("active", 32'h1, {31'h0, interfaceActive});
        wr(4'h4, 8'hC5);
        chk("self id link", 32'h1, {31'h0, selfIdLink});
        pulse(3);
        rd(4'h4, 8'hC5);
    endtask
    task automatic tEvents();
        pulse(0);
        @(posedge clock);
        cable_power_status_input <= 1'h0;
        @(posedge clock);
        pul[1] <= 1'h1;
        waitv(rstStart, 20, "timeout reset");
        @(posedge clock);
        pul[1] <= 1'h0;
        cable_power_status_input <= 1'h1;
        wr(4'h5, 8'h00);
        rd(4'h5, 8'h38);
        wr(4'h5, 8'h38);
        rd(4'h5, 8'h00);
    endtask
    task automatic tPorts();
        wr(4'h7, 8'h00);
        wr(4'h9, 8'h10);
        @(posedge clock);
        portStatus <= 8'h01;
        rd(4'h5, 8'h04);
        wr(4'h5, 8'h04);
        wr(4'h7, 8'h10);
        @(posedge clock);
        portStatus <= 8'h11;
        rd(4'h5, 8'h00);
        chk("port select", 32'h1, {28'h0, portSelect});
        wr(4'h5, 8'h80);
        pulse(2);
        rd(4'h5, 8'h84);
        wr(4'h5, 8'h04);
    endtask
    task automatic tShort();
        waitIdle();
        wr(4'h5, 8'h40);
        rd(4'h5, 8'h40);
        @(posedge clock);
        busIdle <= 1'h1;
        waitv(rstStart, 300, "short reset");
        @(negedge clock);
        chk("short kind", 32'h1, {31'h0, rstShort});
        chk("reset active", 32'h1, {31'h0, rstActive});
        pulse(3);
        rd(4'h5, 8'h00);
        waitIdle();
        @(posedge clock);
        legacy <= 1'h1;
        wr(4'h5, 8'h40);
        waitv(rstStart, 300, "long reset");
        @(negedge clock);
        chk("short kind", 32'h0, {31'h0, rstShort});
        pulse(3);
        legacy <= 1'h0;
        busIdle <= 1'h0;
    endtask
    task automatic tWake();
        pulse(0);
        wr(4'h5, 8'h80);
        @(posedge clock);
        sleepReq <= 1'h1;
        waitv(wakeLink, 20, "wake");
        waitv(interfaceActive, 20, "active");
        wr(4'h5, 8'hA0);
        repeat (8) @(negedge clock);
        chk("active", 32'h0, {31'h0, interfaceActive});
        chk("self id link", 32'h0, {31'h0, selfIdLink});
        @(posedge clock);
        sleepReq <= 1'h0;
        wr(4'h5, 8'h00);
    endtask
    task automatic tMisc();
        wr(4'h5, 8'h03);
        chk("accel", 32'h1, {31'h0, accel});
        chk("multi", 32'h1, {31'h0, multi});
        wr(4'h7, 8'h13);
        chk("page", 32'h3, {29'h0, pageSelect});
        rd(4'h8, 8'h00);
        @(posedge clock);
        pins <= 3'h2;
        repeat (3) @(posedge clock);
        pulse(4);
        repeat (6) @(posedge clock);
        pulse(3);
        rd(4'h4, 8'hC2);
        rd(4'h5, 8'h03);
        rd(4'h7, 8'h13);
    endtask
    initial begin
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errTotal++;
        closeOut();
    end
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'h0;
        tReset();
        tLink();
        tEvents();
        tPorts();
        tShort();
        tWake();
        tMisc();
        closeOut();
    end
endmodule
